/* File: logic/iagc_regs.sv */
`timescale 1ns/10ps
`include "iagc_consts.svh"

module iagc_regs #(
  parameter int STEP0_CYC = `IAGC_RAMP0_US * `IAGC_CLK_MHZ / `IAGC_GAIN_STEPS,
  parameter int STEP1_CYC = `IAGC_RAMP1_US * `IAGC_CLK_MHZ / `IAGC_GAIN_STEPS,
  parameter int STEP2_CYC = `IAGC_RAMP2_US * `IAGC_CLK_MHZ / `IAGC_GAIN_STEPS
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Control port
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wr_data,
  input  wire logic        reg_rd_en,
  output logic      [7:0]  reg_rd_data,
  output logic             reg_rd_valid,
  // Input mode select
  output logic             amp_mic_select_ch0,
  output logic             amp_mic_select_ch1,
  output logic             amp_mic_select_ch2,
  output logic             amp_mic_select_ch3,
  // Mute
  output logic             amp_mute_ch0,
  output logic             amp_mute_ch1,
  output logic             amp_mute_ch2,
  output logic             amp_mute_ch3,
  // Applied gain codes
  output logic      [5:0]  amp_gain_code_ch0,
  output logic      [5:0]  amp_gain_code_ch1,
  output logic      [5:0]  amp_gain_code_ch2,
  output logic      [5:0]  amp_gain_code_ch3,
  // Boost
  output logic             extra_gain_ch0,
  output logic             extra_gain_ch1,
  output logic             extra_gain_ch2,
  output logic             extra_gain_ch3
);

  localparam int CNT_W = 16;
  localparam int NCH   = `IAGC_NUM_CH;

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0]       ctrl_r [NCH];
  logic [7:0]       ctrl_nxt [NCH];
  logic [7:0]       slew_r, slew_nxt;
  logic [7:0]       boost_r, boost_nxt;
  logic [7:0]       rd_data_r, rd_data_nxt;
  logic             rd_valid_r, rd_valid_nxt;
  logic [5:0]       gain_w [NCH];
  logic [NCH-1:0]   busy_w;
  logic [1:0]       rate_w;
  logic [CNT_W-1:0] step_sel;

  // Write decode for all writable registers
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      ctrl_nxt[i] = ctrl_r[i];
    end
    slew_nxt  = slew_r;
    boost_nxt = boost_r;
    if (reg_wr_en) begin
      unique case (reg_addr)
        `IAGC_CTRL_CH0_ADDR: ctrl_nxt[0] = reg_wr_data;
        `IAGC_CTRL_CH1_ADDR: ctrl_nxt[1] = reg_wr_data;
        `IAGC_CTRL_CH2_ADDR: ctrl_nxt[2] = reg_wr_data;
        `IAGC_CTRL_CH3_ADDR: ctrl_nxt[3] = reg_wr_data;
        `IAGC_SLEW_ADDR:     slew_nxt    = reg_wr_data;
        `IAGC_BOOST_ADDR:    boost_nxt   = reg_wr_data;
        default: begin
          slew_nxt = slew_r;                                         // Unmapped write ignored
        end
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_r[i] <= `IAGC_CTRL_RESET;
      end
      slew_r  <= `IAGC_SLEW_RESET;
      boost_r <= `IAGC_BOOST_RESET;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_r[i] <= ctrl_nxt[i];
      end
      slew_r  <= slew_nxt;
      boost_r <= boost_nxt;
    end
  end

  // ****************************************
  // Read path
  // ****************************************

  // Read mux; unmapped offsets return zero
  always_comb begin
    rd_valid_nxt = reg_rd_en;
    rd_data_nxt  = rd_data_r;
    if (reg_rd_en) begin
      unique case (reg_addr)
        `IAGC_CTRL_CH0_ADDR: rd_data_nxt = ctrl_r[0];
        `IAGC_CTRL_CH1_ADDR: rd_data_nxt = ctrl_r[1];
        `IAGC_CTRL_CH2_ADDR: rd_data_nxt = ctrl_r[2];
        `IAGC_CTRL_CH3_ADDR: rd_data_nxt = ctrl_r[3];
        `IAGC_SLEW_ADDR:     rd_data_nxt = slew_r;
        `IAGC_BOOST_ADDR:    rd_data_nxt = boost_r;
        `IAGC_STATUS_ADDR:   rd_data_nxt = {4'h0, busy_w};           // Ramp in progress
        default:             rd_data_nxt = 8'h00;
      endcase
    end
  end

  // Read data flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  assign reg_rd_data  = rd_data_r;
  assign reg_rd_valid = rd_valid_r;

  // ****************************************
  // Gain ramping
  // ****************************************

  // Step interval from rate field; reserved code 11 runs at slowest rate
  assign rate_w = slew_r[`IAGC_RATE_MSB:`IAGC_RATE_LSB];

  always_comb begin
    if (rate_w == `IAGC_RATE_FAST) begin
      step_sel = CNT_W'(STEP0_CYC);
    end else if (rate_w == `IAGC_RATE_MID) begin
      step_sel = CNT_W'(STEP1_CYC);
    end else begin
      step_sel = CNT_W'(STEP2_CYC);
    end
  end

  // One ramp engine per channel
  generate
    for (genvar ch = 0; ch < NCH; ch++) begin : g_ramp
      iagc_ramp #(
        .CNT_W    (CNT_W)
      ) u_ramp (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .power_on (ctrl_r[ch][`IAGC_MIC_BIT]),
        .mute     (ctrl_r[ch][`IAGC_MUTE_BIT]),
        .ramp_off (slew_r[ch]),
        .target   (ctrl_r[ch][`IAGC_GAIN_MSB:`IAGC_GAIN_LSB]),
        .step_cyc (step_sel),
        .gain_out (gain_w[ch]),
        .busy     (busy_w[ch])
      );
    end
  endgenerate

  // ****************************************
  // Analog control outputs
  // ****************************************

  // Mode select, all from control flops
  assign amp_mic_select_ch0 = ctrl_r[0][`IAGC_MIC_BIT];
  assign amp_mic_select_ch1 = ctrl_r[1][`IAGC_MIC_BIT];
  assign amp_mic_select_ch2 = ctrl_r[2][`IAGC_MIC_BIT];
  assign amp_mic_select_ch3 = ctrl_r[3][`IAGC_MIC_BIT];

  // Mute flags
  assign amp_mute_ch0 = ctrl_r[0][`IAGC_MUTE_BIT];
  assign amp_mute_ch1 = ctrl_r[1][`IAGC_MUTE_BIT];
  assign amp_mute_ch2 = ctrl_r[2][`IAGC_MUTE_BIT];
  assign amp_mute_ch3 = ctrl_r[3][`IAGC_MUTE_BIT];

  // Applied gain from ramp engine level flops
  assign amp_gain_code_ch0 = gain_w[0];
  assign amp_gain_code_ch1 = gain_w[1];
  assign amp_gain_code_ch2 = gain_w[2];
  assign amp_gain_code_ch3 = gain_w[3];

  // Boost adds 10 dB at once, no ramp
  assign extra_gain_ch0 = boost_r[0];
  assign extra_gain_ch1 = boost_r[1];
  assign extra_gain_ch2 = boost_r[2];
  assign extra_gain_ch3 = boost_r[3];

endmodule

/* File: logic/iagc_consts.svh */
// Summary of operation
// - Gain code bits 5..0 map 0 to -12 dB, 0.75 dB steps, 63 to +35.25 dB.
// - Control bit 7 clear gives line input, amp off; set gives mic, amp on with ramp.
// - Control bit 6 mutes the amp, resets set; while muted gain code is ignored.
// - Channel two control at 0x0025, channel three at 0x0026, reset 0x40, read-write.
// - Slew register bits 5..4 pick ramp time: 21.5 ms, 42.5 ms or 85 ms.
// - Slew register bits 3..0 disable ramping per channel; rate then ignored.
// - Boost register 0x0028 bits 3..0 add 10 dB per channel, range -2 to +45.25 dB.
// - Slew register at 0x0027 resets to zero: all channels ramp at fastest rate.
// - Channel zero and one control at 0x0023 and 0x0024, same layout and reset.
`ifndef IAGC_CONSTS_SVH
`define IAGC_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define IAGC_CTRL_CH0_ADDR   16'h0023
`define IAGC_CTRL_CH1_ADDR   16'h0024
`define IAGC_CTRL_CH2_ADDR   16'h0025
`define IAGC_CTRL_CH3_ADDR   16'h0026
`define IAGC_SLEW_ADDR       16'h0027
`define IAGC_BOOST_ADDR      16'h0028
`define IAGC_STATUS_ADDR     16'h00ff

// ****************************************
// Reset values and field positions
// ****************************************
`define IAGC_CTRL_RESET      8'h40
`define IAGC_SLEW_RESET      8'h00
`define IAGC_BOOST_RESET     8'h00
`define IAGC_MIC_BIT         7
`define IAGC_MUTE_BIT        6
`define IAGC_GAIN_MSB        5
`define IAGC_GAIN_LSB        0
`define IAGC_RATE_MSB        5
`define IAGC_RATE_LSB        4
`define IAGC_RATE_FAST       2'h0
`define IAGC_RATE_MID        2'h1
`define IAGC_GAIN_ZERO       6'h00
`define IAGC_NUM_CH          4

// ****************************************
// Timing
// ****************************************
`define IAGC_CLK_MHZ         20
`define IAGC_RAMP0_US        21500
`define IAGC_RAMP1_US        42500
`define IAGC_RAMP2_US        85000
`define IAGC_GAIN_STEPS      64

`endif

/* File: logic/iagc_pkg.sv */
package iagc_pkg;

  // ****************************************
  // Ramp engine states
  // ****************************************
  typedef enum logic [1:0] {
    IAGC_RS_IDLE = 2'b01,
    IAGC_RS_RAMP = 2'b10
  } iagc_ramp_state_t;

endpackage

/* File: logic/iagc_ramp.sv */
`timescale 1ns/10ps
`include "iagc_consts.svh"

module iagc_ramp #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // Channel controls
  input  wire logic             power_on,
  input  wire logic             mute,
  input  wire logic             ramp_off,
  input  wire logic [5:0]       target,
  input  wire logic [CNT_W-1:0] step_cyc,
  // Applied gain
  output logic      [5:0]       gain_out,
  output logic                  busy
);

  iagc_pkg::iagc_ramp_state_t state_r, state_nxt;
  logic [CNT_W-1:0]           cnt_r, cnt_nxt;
  logic [5:0]                 level_r, level_nxt;

  // Next gain level and step timer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    level_nxt = level_r;
    if (!power_on) begin
      state_nxt = iagc_pkg::IAGC_RS_IDLE;
      level_nxt = `IAGC_GAIN_ZERO;
      cnt_nxt   = '0;
    end else if (mute) begin
      state_nxt = state_r;
    end else if (ramp_off) begin
      state_nxt = iagc_pkg::IAGC_RS_IDLE;
      level_nxt = target;
    end else begin
      unique case (state_r)
        iagc_pkg::IAGC_RS_IDLE: begin
          if (level_r != target) begin
            state_nxt = iagc_pkg::IAGC_RS_RAMP;
            cnt_nxt   = step_cyc - 1'b1;
          end
        end
        iagc_pkg::IAGC_RS_RAMP: begin
          if (level_r == target) begin
            state_nxt = iagc_pkg::IAGC_RS_IDLE;
          end else if (cnt_r == '0) begin
            level_nxt = (level_r < target) ? level_r + 6'h01 : level_r - 6'h01;
            cnt_nxt   = step_cyc - 1'b1;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
        default: begin
          state_nxt = iagc_pkg::IAGC_RS_IDLE;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_r <= iagc_pkg::IAGC_RS_IDLE;
      cnt_r   <= '0;
      level_r <= `IAGC_GAIN_ZERO;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      level_r <= level_nxt;
    end
  end

  // Outputs straight from state
  assign gain_out = level_r;
  assign busy     = (state_r == iagc_pkg::IAGC_RS_RAMP);

endmodule

/* File: tb/iagc_regs_sva.sv */
`timescale 1ns/10ps

module iagc_regs_sva (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // Control port
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr_en,
  input wire logic [7:0]  reg_wr_data,
  input wire logic        reg_rd_en,
  input wire logic [7:0]  reg_rd_data,
  input wire logic        reg_rd_valid,
  // Channel outputs
  input wire logic        amp_mic_select_ch0,
  input wire logic        amp_mic_select_ch2,
  input wire logic        amp_mute_ch0,
  input wire logic        amp_mute_ch3,
  input wire logic [5:0]  amp_gain_code_ch0,
  input wire logic [5:0]  amp_gain_code_ch2,
  input wire logic        extra_gain_ch0,
  input wire logic        extra_gain_ch3
);
  // All checks on the system clock, off during reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // ****************************************
  // Control port
  // ****************************************
  chk_rd_pulse:
    assert property (reg_rd_en |=> reg_rd_valid) else $error("read without valid");
  chk_rd_cause:
    assert property (reg_rd_valid |-> $past(reg_rd_en)) else $error("valid without read");
  chk_unmapped_read:
    assert property (reg_rd_en && reg_addr == 16'h0030 |=> reg_rd_data == 8'h00)
      else $error("unmapped read not zero");
  chk_ctrl0_read:
    assert property (reg_rd_en && reg_addr == 16'h0023 |=> reg_rd_data[7:6] ==
      {$past(amp_mic_select_ch0), $past(amp_mute_ch0)}) else $error("ctrl0 readback");

  // ****************************************
  // Channel controls
  // ****************************************
  chk_mic_write:
    assert property (reg_wr_en && reg_addr == 16'h0025 |=>
      amp_mic_select_ch2 == $past(reg_wr_data[7])) else $error("mic select ch2");
  chk_mute_write:
    assert property (reg_wr_en && reg_addr == 16'h0026 |=>
      amp_mute_ch3 == $past(reg_wr_data[6])) else $error("mute ch3");
  chk_boost_write:
    assert property (reg_wr_en && reg_addr == 16'h0028 |=> {extra_gain_ch3, extra_gain_ch0}
      == {$past(reg_wr_data[3]), $past(reg_wr_data[0])}) else $error("boost bits");
  chk_line_gain_zero:
    assert property (!amp_mic_select_ch2 |=> amp_gain_code_ch2 == 6'h00)
      else $error("line mode gain not zero");
  chk_mute_freeze:
    assert property (amp_mute_ch0 && amp_mic_select_ch0 |=> $stable(amp_gain_code_ch0))
      else $error("gain moved while muted");

  // Main scenarios reached
  cover property (reg_rd_valid);
  cover property (amp_gain_code_ch2 == 6'h3f);
  cover property (amp_mute_ch0 && amp_mic_select_ch0);
endmodule

bind iagc_regs iagc_regs_sva u_iagc_regs_sva (
  .clk_sys, .resetn, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data,
  .reg_rd_valid, .amp_mic_select_ch0, .amp_mic_select_ch2, .amp_mute_ch0, .amp_mute_ch3,
  .amp_gain_code_ch0, .amp_gain_code_ch2, .extra_gain_ch0, .extra_gain_ch3
);

/* File: tb/iagc_regs_tb.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end

module iagc_regs_tb;
  logic        clk_sys     = 1'b0;
  logic        resetn      = 1'b0;
  logic [15:0] reg_addr    = 16'h0000;
  logic        reg_wr_en   = 1'b0;
  logic [7:0]  reg_wr_data = 8'h00;
  logic        reg_rd_en   = 1'b0;
  logic [7:0]  reg_rd_data;
  logic        reg_rd_valid;
  logic [3:0]  mic;
  logic [3:0]  mute;
  logic [3:0]  boost;
  logic [5:0]  gain [4];
  logic [31:0] seed        = 32'h000112c7;
  logic [7:0]  dtab [4]    = '{8'h90, 8'hbf, 8'h80, 8'h3f};
  int          step_tab [4] = '{4, 6, 8, 8};
  int          err_total   = 0;
  int          num_checks  = 0;
  int          n;
  int          k;

  // Short step counts keep the ramps brief
  iagc_regs #(.STEP0_CYC(4), .STEP1_CYC(6), .STEP2_CYC(8)) u_iagc_regs (
    .clk_sys, .resetn, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data,
    .reg_rd_valid, .amp_mic_select_ch0(mic[0]), .amp_mic_select_ch1(mic[1]),
    .amp_mic_select_ch2(mic[2]), .amp_mic_select_ch3(mic[3]), .amp_mute_ch0(mute[0]),
    .amp_mute_ch1(mute[1]), .amp_mute_ch2(mute[2]), .amp_mute_ch3(mute[3]),
    .amp_gain_code_ch0(gain[0]), .amp_gain_code_ch1(gain[1]), .amp_gain_code_ch2(gain[2]),
    .amp_gain_code_ch3(gain[3]), .extra_gain_ch0(boost[0]), .extra_gain_ch1(boost[1]),
    .extra_gain_ch2(boost[2]), .extra_gain_ch3(boost[3]));

  // System clock, 50 ns period
  always #25 clk_sys = ~clk_sys;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Applied gain with ramping off: line mode forces code zero
  function automatic logic [5:0] exp_gain(input logic [7:0] d);
    return d[7] ? d[5:0] : 6'h00;
  endfunction

  // One-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #2;
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(posedge clk_sys);
    #2;
    reg_wr_en = 1'b0;
  endtask

  // One-cycle read strobe, answer checked the cycle after
  task automatic rd(input logic [15:0] a, input logic [7:0] ex);
    @(posedge clk_sys);
    #2;
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge clk_sys);
    #2;
    reg_rd_en = 1'b0;
    `CHK("rd_valid", 1'b1, reg_rd_valid)
    `CHK("rd_data", ex, reg_rd_data)
  endtask

  // Counts cycles until channel zero gain reaches a value
  task automatic wait_g(input logic [5:0] v);
    n = 0;
    while (gain[0] !== v && n < 100) begin
      @(posedge clk_sys);
      #2;
      n++;
    end
    if (n == 100) begin
      err_total++;
      stop_test();
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clk_sys);
    #2;
    resetn = 1'b1;
    `CHK("mute_rst", 4'hf, mute)
    `CHK("mic_rst", 4'h0, mic)
    `CHK("gain_rst", 6'h00, gain[0])
    `CHK("boost_rst", 4'h0, boost)
    for (int a = 0; a < 6; a++) begin
      rd(16'h0023 + 16'(a), (a < 4) ? 8'h40 : 8'h00);
    end
    // Random writes with readback, hand-picked unmapped offset after
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      k = int'(seed[7:0] % 8'h06);
      wr(16'h0023 + 16'(k), seed[15:8]);
      if (k < 4) `CHK("mode", seed[15:14], {mic[k], mute[k]})
      else if (k == 5) `CHK("boost", seed[11:8], boost)
      rd(16'h0023 + 16'(k), seed[15:8]);
    end
    wr(16'h0030, 8'hff);
    rd(16'h0030, 8'h00);
    // Ramp disabled with slowest rate set: gain applied at once
    wr(16'h0027, 8'h2f);
    foreach (dtab[j]) begin
      for (int c = 0; c < 4; c++) begin
        wr(16'h0023 + 16'(c), dtab[j]);
        @(posedge clk_sys);
        #2;
        `CHK("gain_now", exp_gain(dtab[j]), gain[c])
      end
    end
    // Each rate code, reserved one too; only channel zero ramps
    for (int r = 0; r < 4; r++) begin
      wr(16'h0027, {2'h0, 2'(r), 4'he});
      wr(16'h0023, 8'h00);
      wr(16'h0023, 8'h82);
      wait_g(6'h01);
      wait_g(6'h02);
      `CHK("step_cyc", step_tab[r], n)
    end
    // Channel one ramp off: rate ignored, gain applied at once
    wr(16'h0024, 8'hbf);
    @(posedge clk_sys);
    #2;
    `CHK("gain1_now", 6'h3f, gain[1])
    // Muted gain ignores new code, unmute resumes the ramp
    wr(16'h0023, 8'hc9);
    repeat (20) @(posedge clk_sys);
    #2;
    `CHK("gain0_muted", 6'h02, gain[0])
    wr(16'h0023, 8'h89);
    rd(16'h00ff, 8'h01);
    wait_g(6'h09);
    rd(16'h00ff, 8'h00);
    stop_test();
  end
endmodule
